// ===== hw/sequencer_slot_config_regs.sv
// Slot and voltage configuration registers with AHB-Lite slave
//
// Functional notes
// - Slot codes 110/111 select hardware enable 1/2
// - Regulator 9 codes 00h-0Ch: 1.00-1.60V, 50mV
// - Regulator 9 code 0Dh 1.70V, 100mV steps
// - Regulator 11 codes 0h-Fh: 0.80-1.55V, 50mV
// - Regulator 11 slot 15:13, voltage 11:8
// - Slave bit set: buck 4 follows buck 3
// - Slave bit changes only by configuration load
// - All documented fields reset to zero
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "slot_config_consts.svh"

module sequencer_slot_config_regs
   import slot_config_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        clk_en,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Configuration loader from one-time memory or external config memory
   input  wire load_req_t   load_req,
   // Sequencer view
   output logic      [4:0]  regulator_9_voltage_code,
   output logic      [15:0] regulator_9_millivolts,
   output logic      [2:0]  regulator_11_slot_select,
   output logic      [3:0]  regulator_11_voltage_code,
   output logic      [15:0] regulator_11_millivolts,
   output logic      [2:0]  external_enable_2_slot_select,
   output logic      [2:0]  external_enable_1_slot_select,
   output slot_route_t      regulator_11_route,
   output slot_route_t      external_enable_2_route,
   output slot_route_t      external_enable_1_route,
   output logic             buck_4_slave_mode
);

   // ==========================================
   // Helpers
   // Codes 1-5 pass through as timeslots, 6 and 7 hand over to pins
   function automatic slot_route_t decode_slot(input logic [2:0] code);
      slot_route_t r;
      r = '0;
      case (slot_code_t'(code))
         SLOT_NEVER:  r = '0;
         SLOT_HW_EN1: r.hw_enable_1 = 1'b1;
         SLOT_HW_EN2: r.hw_enable_2 = 1'b1;
         default: begin
            r.in_sequence = 1'b1;
            r.timeslot    = code;
         end
      endcase
      return r;
   endfunction

   // Two linear segments meeting at the knee code
   function automatic logic [15:0] reg9_mv(input logic [4:0] code);
      logic [15:0] c;
      c = {11'h000, code};
      if (code < `R9_KNEE_CODE)
         return 16'(`R9_BASE_MV + c * `R9_STEP_LO_MV);
      else
         return 16'(`R9_KNEE_MV + (c - 16'h000D) * `R9_STEP_HI_MV);
   endfunction

   // ==========================================
   // Bus address phase capture
   logic [15:0] reg11;
   logic [15:0] next_reg11;
   logic        loader_lock;
   logic        next_lock;
   bus_phase_t  phase;
   logic [31:0] ph_addr;
   logic        ph_write;
   logic        ph_bad;
   logic [4:0]  next_vsel9;
   logic        take;

   assign take = clk_en && hsel && hready && htrans[1];
   // Sub-word or misaligned transfers never write

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase    <= PH_IDLE;
         ph_addr  <= 32'h0000_0000;
         ph_write <= 1'b0;
         ph_bad   <= 1'b0;
      end else if (clk_en && hready) begin
         phase    <= take ? PH_DATA : PH_IDLE;
         ph_addr  <= haddr;
         ph_write <= hwrite;
         ph_bad   <= (hsize != 3'b010) || (haddr[1:0] != 2'b00);
      end
   end

   logic wr_ok;
   assign wr_ok = clk_en && (phase == PH_DATA) && ph_write && !ph_bad;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ==========================================
   // Register 9/10 (only regulator 9 voltage field is held here)
   logic [4:0] vsel9;
   // Loader wins over a same-cycle bus write
   always_comb begin
      next_vsel9 = vsel9;
      if (wr_ok && ph_addr == 32'(`REG9_10_ADDR))
         next_vsel9 = hwdata[`R9_VSEL_MSB:`R9_VSEL_LSB];
      if (clk_en && load_req.valid && !load_req.to_reg11)
         next_vsel9 = load_req.data[`R9_VSEL_MSB:`R9_VSEL_LSB];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         vsel9 <= 5'(`REG9_10_RESET);
      else
         vsel9 <= next_vsel9;
   end

   // ==========================================
   // Register 11 / external enables / slave bit
   // Loader wins over a same-cycle bus write
   always_comb begin
      next_reg11 = reg11;
      if (wr_ok && ph_addr == 32'(`REG11_ADDR) && !loader_lock)
         next_reg11 = (hwdata[15:0] & `REG11_WMASK) |
                      {15'h0000, reg11[`SLAVE_BIT]};
      if (clk_en && load_req.valid && load_req.to_reg11)
         next_reg11 = (load_req.data & `REG11_WMASK) |
                      {15'h0000, load_req.data[`SLAVE_BIT]};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         reg11 <= `REG11_RESET;
      else
         reg11 <= next_reg11;
   end

   // Software write lock for bus writes to register 11
   always_comb begin
      next_lock = loader_lock;
      if (wr_ok && ph_addr == `LOADER_CTRL_ADDR)
         next_lock = hwdata[0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         loader_lock <= 1'b0;
      else
         loader_lock <= next_lock;
   end

   // ==========================================
   // Read data
   // Next values, so a read right behind a write sees the new word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (take && !hwrite) begin
         case (haddr)
            32'(`REG9_10_ADDR):  hrdata <= {27'h0000000, next_vsel9};
            32'(`REG11_ADDR):    hrdata <= {16'h0000, next_reg11};
            `LOADER_CTRL_ADDR:   hrdata <= {31'h00000000, next_lock};
            `DECODE_STATUS_ADDR: hrdata <= {16'h0000, reg9_mv(next_vsel9)};
            default:             hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================
   // Sequencer outputs
   // Registered copies, one cycle behind the registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         regulator_9_voltage_code      <= 5'h00;
         regulator_9_millivolts        <= `R9_BASE_MV;
         regulator_11_slot_select      <= 3'h0;
         regulator_11_voltage_code     <= 4'h0;
         regulator_11_millivolts       <= `R11_BASE_MV;
         external_enable_2_slot_select <= 3'h0;
         external_enable_1_slot_select <= 3'h0;
         regulator_11_route            <= '0;
         external_enable_2_route       <= '0;
         external_enable_1_route       <= '0;
         buck_4_slave_mode             <= 1'b0;
      end else if (clk_en) begin
         regulator_9_voltage_code      <= vsel9;
         regulator_9_millivolts        <= reg9_mv(vsel9);
         regulator_11_slot_select      <= reg11[`R11_SLOT_MSB:`R11_SLOT_LSB];
         regulator_11_voltage_code     <= reg11[`R11_VSEL_MSB:`R11_VSEL_LSB];
         regulator_11_millivolts       <= 16'(`R11_BASE_MV +
            {12'h000, reg11[`R11_VSEL_MSB:`R11_VSEL_LSB]} * `R11_STEP_MV);
         external_enable_2_slot_select <= reg11[`EXT2_SLOT_MSB:`EXT2_SLOT_LSB];
         external_enable_1_slot_select <= reg11[`EXT1_SLOT_MSB:`EXT1_SLOT_LSB];
         regulator_11_route      <= decode_slot(reg11[`R11_SLOT_MSB:`R11_SLOT_LSB]);
         external_enable_2_route <= decode_slot(reg11[`EXT2_SLOT_MSB:`EXT2_SLOT_LSB]);
         external_enable_1_route <= decode_slot(reg11[`EXT1_SLOT_MSB:`EXT1_SLOT_LSB]);
         buck_4_slave_mode       <= reg11[`SLAVE_BIT];
      end
   end

   // Bus bits this bank never looks at
   logic unused;
   assign unused = ^hwdata[31:16] | htrans[0];

endmodule
`default_nettype wire

// ===== hw/slot_config_consts.svh
// Offsets, field positions and reset values of the slot configuration registers
`ifndef SLOT_CONFIG_CONSTS_SVH
`define SLOT_CONFIG_CONSTS_SVH

// ==========================================
// Register indices and byte addresses
`define REG9_10_INDEX      16'h7818
`define REG11_INDEX        16'h7819
`define REG9_10_ADDR       (`REG9_10_INDEX * 4)
`define REG11_ADDR         (`REG11_INDEX * 4)
`define LOADER_CTRL_ADDR   32'h0001_F000
`define DECODE_STATUS_ADDR 32'h0001_F004

// ==========================================
// Field positions
`define R9_VSEL_MSB   4
`define R9_VSEL_LSB   0
`define R11_SLOT_MSB  15
`define R11_SLOT_LSB  13
`define R11_VSEL_MSB  11
`define R11_VSEL_LSB  8
`define EXT2_SLOT_MSB 7
`define EXT2_SLOT_LSB 5
`define EXT1_SLOT_MSB 4
`define EXT1_SLOT_LSB 2
`define SLAVE_BIT     0
`define REG11_WMASK   16'hEFFC

// ==========================================
// Reset values
`define REG9_10_RESET 16'h0000
`define REG11_RESET   16'h0000

// ==========================================
// Voltage code breakpoints, millivolts
`define R9_BASE_MV    16'd1000
`define R9_STEP_LO_MV 16'd50
`define R9_KNEE_CODE  5'h0D
`define R9_KNEE_MV    16'd1700
`define R9_STEP_HI_MV 16'd100
`define R11_BASE_MV   16'd800
`define R11_STEP_MV   16'd50

`endif

// ===== hw/slot_config_pkg.sv
// Types shared by the slot configuration register bank
`default_nettype none
package slot_config_pkg;

   // ==========================================
   // Slot select meaning
   typedef enum logic [2:0] {
      SLOT_NEVER  = 3'b000,
      SLOT_1      = 3'b001,
      SLOT_2      = 3'b010,
      SLOT_3      = 3'b011,
      SLOT_4      = 3'b100,
      SLOT_5      = 3'b101,
      SLOT_HW_EN1 = 3'b110,
      SLOT_HW_EN2 = 3'b111
   } slot_code_t;

   // Decoded enable source for one output
   typedef struct packed {
      logic       in_sequence;
      logic [2:0] timeslot;
      logic       hw_enable_1;
      logic       hw_enable_2;
   } slot_route_t;

   // Configuration loader write port
   typedef struct packed {
      logic        valid;
      logic        to_reg11;
      logic [15:0] data;
   } load_req_t;

   // Bus slave phase state
   typedef enum logic [0:0] {
      PH_IDLE = 1'b0,
      PH_DATA = 1'b1
   } bus_phase_t;

endpackage
`default_nettype wire

// ===== verif/sequencer_slot_config_regs_test.sv
// Self-checking bench for the slot configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "slot_config_consts.svh"
module sequencer_slot_config_regs_test
   import slot_config_pkg::*;
;
   typedef struct packed {logic [15:0] w; logic [4:0] v; logic [15:0] mv;} row_t;
   row_t rows [4] = '{'{16'h102B, 5'h00, 16'd1000}, '{16'h6F94, 5'h0C, 16'd1600},
                      '{16'hC5E0, 5'h0D, 16'd1700}, '{16'hEA58, 5'h1F, 16'd3500}};
   logic             hclk, hresetn, clk_en, hsel, hwrite;
   logic [31:0]      haddr, hwdata, rd;
   logic [1:0]       htrans;
   logic [2:0]       hsize;
   load_req_t        load_req;
   wire logic [31:0] hrdata;
   wire logic        hreadyout, hresp, slave;
   wire logic [2:0]  s11, s2, s1;
   wire logic [3:0]  v11;
   wire logic [4:0]  v9;
   wire logic [15:0] mv9, mv11;
   wire slot_route_t r11, r2, r1;
   int               fail_count = 0;
   int               checked = 0;

   sequencer_slot_config_regs sequencer_slot_config_regs_inst (.hclk, .hresetn, .clk_en, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .load_req, .regulator_9_voltage_code(v9), .regulator_9_millivolts(mv9),
      .regulator_11_slot_select(s11), .regulator_11_voltage_code(v11),
      .regulator_11_millivolts(mv11), .external_enable_2_slot_select(s2),
      .external_enable_1_slot_select(s1), .regulator_11_route(r11), .external_enable_2_route(r2),
      .external_enable_1_route(r1), .buck_4_slave_mode(slave));

   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // ==========================================
   // Helpers
   function automatic logic [2:0] rt(logic [2:0] c);
      return {c inside {[3'h1:3'h5]}, c == 3'h6, c == 3'h7};
   endfunction
   function automatic logic [2:0] gt(slot_route_t r);
      return {r.in_sequence, r.hw_enable_1, r.hw_enable_2};
   endfunction
   task automatic end_of_test();
      if (fail_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic wait_ready();
      int n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         fail_count++;
         end_of_test();
      end
   endtask
   task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      wait_ready();
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
   endtask
   task automatic check_reset();
      bus(0, `REG11_ADDR, 0);
      chk("rst11", 0, rd);
      bus(0, `REG9_10_ADDR, 0);
      chk("rst9", 0, rd);
      bus(0, `LOADER_CTRL_ADDR, 0);
      chk("rst_lock", 0, rd);
      chk("rst_mv", {16'd1000, 16'd800}, {mv9, mv11});
      chk("rst_out", 0, {slave, v9, s11, v11, s2, s1});
   endtask

   // ==========================================
   // Main sequence
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, load_req} = '0;
      clk_en = 1'b1;
      hsize = 3'h2;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      check_reset();
      foreach (rows[i]) begin
         bus(1, `REG11_ADDR, {16'hFFFF, rows[i].w});
         bus(1, `REG9_10_ADDR, {27'h7FFFFFF, rows[i].v});
         bus(0, `REG11_ADDR, 0);
         chk("reg11", rows[i].w & 16'hEFFC, rd);
         bus(0, `REG9_10_ADDR, 0);
         chk("reg9", rows[i].v, rd);
         bus(0, `DECODE_STATUS_ADDR, 0);
         chk("status", rows[i].mv, rd);
         repeat (3) @(posedge hclk);
         chk("fields", rows[i].w & 16'hEFFC, {s11, 1'b0, v11, s2, s1, 2'b0});
         chk("routes", {rt(rows[i].w[15:13]), rt(rows[i].w[7:5]), rt(rows[i].w[4:2])},
             {gt(r11), gt(r2), gt(r1)});
         chk("mv", {rows[i].mv, 16'd800 + 16'd50 * rows[i].w[11:8]}, {mv9, mv11});
         chk("v9", rows[i].v, v9);
      end
      load_req <= {1'b1, 1'b1, 16'h1003};
      @(posedge hclk);
      load_req <= '0;
      bus(1, `REG11_ADDR, 0);
      bus(0, `REG11_ADDR, 0);
      chk("load11", 1, rd);
      repeat (3) @(posedge hclk);
      chk("slave", 1, slave);
      bus(0, 32'h0000_0100, 0);
      chk("unmapped", 0, rd);
      // Lock blocks bus writes to register 11 but not the loader
      bus(1, `LOADER_CTRL_ADDR, 1);
      bus(1, `REG11_ADDR, 32'h0000_A4E0);
      bus(0, `LOADER_CTRL_ADDR, 0);
      chk("lock", 1, rd);
      bus(0, `REG11_ADDR, 0);
      chk("locked11", 1, rd);
      load_req <= {1'b1, 1'b1, 16'h1FFF};
      @(posedge hclk);
      load_req <= '0;
      @(posedge hclk);
      load_req <= {1'b1, 1'b0, 16'hFFF1};
      @(posedge hclk);
      load_req <= '0;
      bus(0, `REG11_ADDR, 0);
      chk("load_locked", 32'h0000_0FFD, rd);
      bus(0, `DECODE_STATUS_ADDR, 0);
      chk("load9", 32'd2100, rd);
      // Sub-word, misaligned and frozen writes must all be dropped
      hsize <= 3'h0;
      bus(1, `REG9_10_ADDR, 5);
      hsize <= 3'h2;
      bus(1, `REG9_10_ADDR + 2, 5);
      clk_en <= 1'b0;
      bus(1, `REG9_10_ADDR, 3);
      load_req <= {1'b1, 1'b0, 16'h0005};
      @(posedge hclk);
      load_req <= '0;
      clk_en <= 1'b1;
      bus(0, `REG9_10_ADDR, 0);
      chk("kept9", 32'h0000_0011, rd);
      chk("mv9_out", 16'd2100, mv9);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      check_reset();
      end_of_test();
   end
endmodule
`default_nettype wire

// ===== verif/slot_regs_checker.sv
// Checker for the slot configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "slot_config_consts.svh"
module slot_regs_checker
   import slot_config_pkg::*;
(
   // Bus side
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        clk_en,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire load_req_t   load_req,
   // Sequencer view
   input wire logic [4:0]  regulator_9_voltage_code,
   input wire logic [15:0] regulator_9_millivolts,
   input wire logic [2:0]  regulator_11_slot_select,
   input wire logic [3:0]  regulator_11_voltage_code,
   input wire logic [15:0] regulator_11_millivolts,
   input wire slot_route_t regulator_11_route,
   input wire logic        buck_4_slave_mode
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic take = hsel && hready && htrans[1] && clk_en;
   wire logic [2:0] s = regulator_11_slot_select;
   wire slot_route_t r = regulator_11_route;
   wire logic [4:0] c9 = regulator_9_voltage_code;

   property write9_p;
      logic [4:0] d;
      (take && hwrite && hsize == 3'h2 && haddr == `REG9_10_ADDR ##1
         (clk_en && !(load_req.valid && !load_req.to_reg11), d = hwdata[4:0]) ##1 clk_en)
         |=> c9 == d;
   endproperty

   ready_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready");
   slave_hold_a: assert property ($changed(buck_4_slave_mode) |->
      $past(load_req.valid) || $past(load_req.valid, 2)) else $error("slave bit moved by bus");
   slot_hw_a: assert property (r.hw_enable_1 == (s == 3'h6) && r.hw_enable_2 == (s == 3'h7))
      else $error("hardware enable decode wrong");
   slot_seq_a: assert property (r.in_sequence == (s inside {[3'h1:3'h5]}))
      else $error("sequence decode wrong");
   slot_time_a: assert property (r.in_sequence |-> r.timeslot == s) else $error("timeslot wrong");
   mv9_low_a: assert property (c9 <= 5'h0C |-> regulator_9_millivolts == 16'd1000 + 16'd50 * c9)
      else $error("low voltage map wrong");
   mv9_high_a: assert property (c9 >= 5'h0D |->
      regulator_9_millivolts == 16'd1700 + 16'd100 * (c9 - 5'h0D)) else $error("high map wrong");
   mv11_a: assert property (regulator_11_millivolts == 16'd800 + 16'd50 * regulator_11_voltage_code)
      else $error("regulator 11 map wrong");
   read_zero_a: assert property (take && !hwrite && haddr == `REG11_ADDR |=>
      hrdata[31:16] == 16'h0 && !hrdata[12] && !hrdata[1]) else $error("unused bits not zero");
   write9_a: assert property (write9_p) else $error("voltage code not stored");
   reset_zero_a: assert property (disable iff (1'b0) $rose(hresetn) |-> c9 == 5'h0 && s == 3'h0
      && !buck_4_slave_mode && regulator_9_millivolts == 16'd1000) else $error("reset value wrong");

   cover property (take && hwrite);
   cover property (load_req.valid && load_req.data[0]);
   cover property (r.hw_enable_2);
endmodule
bind sequencer_slot_config_regs slot_regs_checker slot_regs_checker_inst (.hclk, .hresetn,
   .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
   .hresp, .load_req, .regulator_9_voltage_code, .regulator_9_millivolts,
   .regulator_11_slot_select, .regulator_11_voltage_code, .regulator_11_millivolts,
   .regulator_11_route, .buck_4_slave_mode);
`default_nettype wire
